// [include/fsrpc_pkg.sv]
// Constants for the fail-safe, reset and pin configuration register group.
// Assumes a 25 MHz core clock and a decoded serial register port in front.
package fsrpc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] FSRPC_ADDR_FAILSAFE_COUNTER = 8'h18;
  localparam logic [7:0] FSRPC_ADDR_DEVICE_RESET     = 8'h19;
  localparam logic [7:0] FSRPC_ADDR_OUTPUT_PIN_CFG   = 8'h1A;
  localparam logic [7:0] FSRPC_ADDR_WAKE_FILTER_CFG  = 8'h1B;

  // Field positions
  localparam int FSRPC_THR_LSB       = 4;
  localparam int FSRPC_SOFT_RST_BIT  = 1;
  localparam int FSRPC_HARD_RST_BIT  = 0;
  localparam int FSRPC_REG_DIS_BIT   = 6;
  localparam int FSRPC_FUNC_SEL_BIT  = 5;
  localparam int FSRPC_FB_DIS_BIT    = 4;
  localparam int FSRPC_OFF_METH_LSB  = 2;
  localparam int FSRPC_FB_OFF_BIT    = 1;
  localparam int FSRPC_WAKE_OFF_BIT  = 1;

  // Reset values and counter limits
  localparam logic [3:0] FSRPC_THR_RST      = 4'h0;
  localparam logic [4:0] FSRPC_CNT_RST      = 5'h00;
  localparam logic [4:0] FSRPC_CNT_CAP      = 5'h10;
  localparam logic [3:0] FSRPC_STAT_MAX     = 4'hF;
  localparam logic [1:0] FSRPC_OFF_METH_RST = 2'h0;
  localparam logic [2:0] FSRPC_REASON_RST   = 3'h0;
  localparam logic [7:0] FSRPC_RDATA_RST    = 8'h00;

  // Fail-safe actions
  localparam logic [2:0] FSRPC_ACT_NONE    = 3'h0;
  localparam logic [2:0] FSRPC_ACT_REG_OFF = 3'h1;
  localparam logic [2:0] FSRPC_ACT_SOFT    = 3'h2;
  localparam logic [2:0] FSRPC_ACT_POR     = 3'h3;
  localparam logic [2:0] FSRPC_ACT_SLEEP   = 3'h4;

  // Fallback turn-off methods
  localparam logic [1:0] FSRPC_OFF_THIRD = 2'h0;
  localparam logic [1:0] FSRPC_OFF_FIRST = 2'h1;
  localparam logic [1:0] FSRPC_OFF_WRITE = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int FSRPC_CLK_HZ        = 25_000_000;
  localparam int FSRPC_REG_OFF_MS    = 1000;
  localparam int FSRPC_REG_OFF_CYCLES = (FSRPC_CLK_HZ / 1000) * FSRPC_REG_OFF_MS;
  localparam int FSRPC_TIMER_W       = 25;

endpackage

// [core/fsrpc_hold_timer.sv]
// One-shot hold timer: busy for a fixed number of cycles after start.
// Assumes start is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module fsrpc_hold_timer
  import fsrpc_pkg::*;
#(
  parameter int CYCLES = FSRPC_REG_OFF_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);

  // ****************************************************************
  // Down counter
  // ****************************************************************
  logic [FSRPC_TIMER_W-1:0] count_ff;

  // Restart on every start; a retrigger extends the hold
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= '0;
    end else if (start) begin
      count_ff <= FSRPC_TIMER_W'(CYCLES);
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign busy = (count_ff != '0);

endmodule

// [core/fsrpc_regs.sv]
// Fail-safe counter, reset control and shared pin configuration registers.
// Assumes a decoded serial register port and event pulses from the rest of the chip.
`timescale 1ns/1ps
module fsrpc_regs
  import fsrpc_pkg::*;
#(
  parameter int REG_OFF_CYCLES = FSRPC_REG_OFF_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       sleep_mode,
  input  wire logic       io_supply,
  input  wire logic       failsafe_entry,
  input  wire logic [2:0] failsafe_reason_in,
  input  wire logic       failsafe_count_enable,
  input  wire logic [2:0] failsafe_action_select,
  input  wire logic       fallback_set,
  input  wire logic       wd_first_good_trigger,
  input  wire logic       wd_third_good_trigger,
  output logic            shared_pin_out,
  output logic [2:0]      failsafe_reason,
  output logic            wake_max_pulse_check_off,
  output logic            soft_reset_out,
  output logic            por_request,
  output logic            power_up_set,
  output logic            wake_ignore_lock
);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  logic       access_ok;
  logic       wr_cnt, wr_rst, wr_pin, wr_wake;
  logic       reg_clr;
  logic       soft_pulse_ff, hard_pulse_ff;

  // Port stays live in sleep while IO supply is up
  assign access_ok = ~sleep_mode | io_supply;
  assign wr_cnt  = reg_wr_en & access_ok & (reg_addr == FSRPC_ADDR_FAILSAFE_COUNTER);
  assign wr_rst  = reg_wr_en & access_ok & (reg_addr == FSRPC_ADDR_DEVICE_RESET);
  assign wr_pin  = reg_wr_en & access_ok & (reg_addr == FSRPC_ADDR_OUTPUT_PIN_CFG);
  assign wr_wake = reg_wr_en & access_ok & (reg_addr == FSRPC_ADDR_WAKE_FILTER_CFG);
  // Either reset returns registers to defaults
  assign reg_clr = sys_rst | soft_pulse_ff | hard_pulse_ff;

  // ****************************************************************
  // Fail-safe entry counter
  // ****************************************************************
  logic [3:0] thr_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] base_cnt;
  logic       cnt_clear, entry_ev, fire;
  logic [3:0] stat_view;

  // Threshold, stored as count minus one
  always_ff @(posedge clk) begin
    if (reg_clr) begin
      thr_ff <= FSRPC_THR_RST;
    end else if (wr_cnt) begin
      thr_ff <= reg_wdata[FSRPC_THR_LSB +: 4];
    end
  end

  assign cnt_clear = wr_cnt & (reg_wdata[3:0] == 4'h0);
  assign entry_ev  = failsafe_entry & failsafe_count_enable;

  // Entry wins over a clear in the same cycle; count starts again at one
  always_comb begin
    base_cnt = cnt_clear ? FSRPC_CNT_RST : cnt_ff;
    nxt_cnt  = base_cnt;
    if (entry_ev && base_cnt != FSRPC_CNT_CAP) begin
      nxt_cnt = base_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reg_clr) begin
      cnt_ff <= FSRPC_CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Internal count runs to 16 so threshold 15 can be met; view caps at 15
  assign stat_view = (cnt_ff > {1'b0, FSRPC_STAT_MAX}) ? FSRPC_STAT_MAX : cnt_ff[3:0];
  // Count rises by one, so equality fires exactly once per run
  assign fire = entry_ev & (cnt_ff != nxt_cnt) & (nxt_cnt == ({1'b0, thr_ff} + 5'h01));

  // Reason captured on entry, held until status cleared
  always_ff @(posedge clk) begin
    if (reg_clr) begin
      failsafe_reason <= FSRPC_REASON_RST;
    end else if (entry_ev) begin
      failsafe_reason <= failsafe_reason_in;
    end else if (cnt_clear) begin
      failsafe_reason <= FSRPC_REASON_RST;
    end
  end

  // ****************************************************************
  // Resets and threshold actions
  // ****************************************************************
  logic timer_start, timer_busy;

  // Reset pulses last one cycle, so their bits read back zero after
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_pulse_ff <= 1'b0;
      hard_pulse_ff <= 1'b0;
    end else begin
      soft_pulse_ff <= (wr_rst & reg_wdata[FSRPC_SOFT_RST_BIT])
                     | (fire & (failsafe_action_select == FSRPC_ACT_SOFT));
      hard_pulse_ff <= (wr_rst & reg_wdata[FSRPC_HARD_RST_BIT])
                     | (fire & (failsafe_action_select == FSRPC_ACT_POR));
    end
  end

  assign soft_reset_out = soft_pulse_ff;
  assign por_request    = hard_pulse_ff;
  assign power_up_set   = hard_pulse_ff;
  assign timer_start    = fire & (failsafe_action_select == FSRPC_ACT_REG_OFF);

  // Sleep lock survives soft and hard resets; only a power cycle clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_ignore_lock <= 1'b0;
    end else if (fire && failsafe_action_select == FSRPC_ACT_SLEEP) begin
      wake_ignore_lock <= 1'b1;
    end
  end

  // Regulator off hold; a soft reset leaves it running
  fsrpc_hold_timer #(
    .CYCLES (REG_OFF_CYCLES)
  ) u_reg_off (
    .clk   (clk),
    .rst   (sys_rst | hard_pulse_ff),
    .start (timer_start),
    .busy  (timer_busy)
  );

  // ****************************************************************
  // Shared pin configuration
  // ****************************************************************
  logic       reg_dis_ff, func_sel_ff, fb_dis_ff, fb_active_ff, fb_off;
  logic [1:0] off_meth_ff;

  always_ff @(posedge clk) begin
    if (reg_clr) begin
      reg_dis_ff  <= 1'b0;
      func_sel_ff <= 1'b0;
      fb_dis_ff   <= 1'b0;
      off_meth_ff <= FSRPC_OFF_METH_RST;
    end else if (wr_pin) begin
      reg_dis_ff  <= reg_wdata[FSRPC_REG_DIS_BIT];
      func_sel_ff <= reg_wdata[FSRPC_FUNC_SEL_BIT];
      fb_dis_ff   <= reg_wdata[FSRPC_FB_DIS_BIT];
      off_meth_ff <= reg_wdata[FSRPC_OFF_METH_LSB +: 2];
    end
  end

  // Turn-off source picked by method; reserved code never turns it off
  always_comb begin
    unique case (off_meth_ff)
      FSRPC_OFF_THIRD: fb_off = wd_third_good_trigger;
      FSRPC_OFF_FIRST: fb_off = wd_first_good_trigger;
      FSRPC_OFF_WRITE: fb_off = wr_pin & reg_wdata[FSRPC_FB_OFF_BIT];
      default:         fb_off = 1'b0;
    endcase
  end

  // Indicator state; a new set wins over a turn-off in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || hard_pulse_ff) begin
      fb_active_ff <= 1'b0;
    end else if (fallback_set) begin
      fb_active_ff <= 1'b1;
    end else if (fb_off) begin
      fb_active_ff <= 1'b0;
    end
  end

  // Pin level; defaults give regulator on, so soft reset keeps it on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shared_pin_out <= 1'b0;
    end else if (func_sel_ff) begin
      shared_pin_out <= fb_active_ff & ~fb_dis_ff;
    end else begin
      shared_pin_out <= ~reg_dis_ff & ~timer_busy;
    end
  end

  // ****************************************************************
  // Wake filter option
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reg_clr) begin
      wake_max_pulse_check_off <= 1'b0;
    end else if (wr_wake) begin
      wake_max_pulse_check_off <= reg_wdata[FSRPC_WAKE_OFF_BIT];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Reset bits read their one-cycle pulse; other self-clearing and reserved bits read zero; unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= FSRPC_RDATA_RST;
    end else if (reg_rd_en && access_ok) begin
      unique case (reg_addr)
        FSRPC_ADDR_FAILSAFE_COUNTER: reg_rdata <= {thr_ff, stat_view};
        FSRPC_ADDR_DEVICE_RESET:     reg_rdata <= {6'h00, soft_pulse_ff, hard_pulse_ff};
        FSRPC_ADDR_OUTPUT_PIN_CFG:   reg_rdata <= {1'b0, reg_dis_ff, func_sel_ff, fb_dis_ff,
                                                   off_meth_ff, 2'h0};
        FSRPC_ADDR_WAKE_FILTER_CFG:  reg_rdata <= {6'h00, wake_max_pulse_check_off, 1'b0};
        default:                     reg_rdata <= FSRPC_RDATA_RST;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_soft_act;
    fire && failsafe_action_select == FSRPC_ACT_SOFT |=> soft_reset_out ##1 !soft_reset_out;
  endproperty
  a_soft_act: assert property (p_soft_act) else $error("soft action missing");

  property p_hard_flag;
    wr_rst && reg_wdata[FSRPC_HARD_RST_BIT] |=> por_request && power_up_set;
  endproperty
  a_hard_flag: assert property (p_hard_flag) else $error("hard reset lost");

  property p_soft_clears;
    soft_pulse_ff |=> thr_ff == FSRPC_THR_RST && !reg_dis_ff && !func_sel_ff;
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset kept regs");

  // Once the view shows 15 it stays there until a clear or reset
  property p_sat;
    stat_view == FSRPC_STAT_MAX && !cnt_clear && !reg_clr |=> stat_view == FSRPC_STAT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("status not saturated");

  property p_clear;
    cnt_clear && !entry_ev && !reg_clr |=> cnt_ff == FSRPC_CNT_RST && failsafe_reason == FSRPC_REASON_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_no_count;
    !failsafe_count_enable && !cnt_clear && !reg_clr |=> $stable(cnt_ff);
  endproperty
  a_no_count: assert property (p_no_count) else $error("count while disabled");

  property p_reg_off;
    timer_start && !func_sel_ff |=> ##1 !shared_pin_out [*4];
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator not off");

  property p_rst_bits_zero;
    reg_rd_en && access_ok && reg_addr == FSRPC_ADDR_DEVICE_RESET && !soft_pulse_ff && !hard_pulse_ff
      |=> reg_rdata == 8'h00;
  endproperty
  a_rst_bits_zero: assert property (p_rst_bits_zero) else $error("reset bits not zero");

  c_fire:  cover property (fire);
  c_sleep: cover property (fire && failsafe_action_select == FSRPC_ACT_SLEEP);
  c_fboff: cover property (fb_active_ff ##1 !fb_active_ff);

endmodule

// [tb/fsrpc_host_model.sv]
// Host model driving the register port of the fail-safe register group.
// Assumes one clk domain; strobes change only just after a rising edge.
`timescale 1ns/1ps
module fsrpc_host_model (
  input  wire logic       clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One byte write; a zero low nibble at 0x18 is the count clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;  // Released lines never keep the old value
    reg_wdata <= ~d;
  endtask

  // One byte read; data is taken the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the fail-safe, reset and pin configuration block.
// Assumes the host model for register access; hold time shortened to 20.
`timescale 1ns/1ps
module tb;
  import fsrpc_pkg::*;
  logic       clk, sys_rst, wr_en, rd_en, sleep_mode, io_supply, fs_entry, cnt_en;
  logic       fb_set, wd_first, wd_third, pin, wake_off, soft_out, por, pup, lock;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] reason, act, reason_out;
  logic [23:0] rows [6];
  int         err_total, comparisons;

  fsrpc_regs #(.REG_OFF_CYCLES(20)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .sleep_mode(sleep_mode), .io_supply(io_supply), .failsafe_entry(fs_entry),
    .failsafe_reason_in(reason), .failsafe_count_enable(cnt_en), .failsafe_action_select(act),
    .fallback_set(fb_set), .wd_first_good_trigger(wd_first), .wd_third_good_trigger(wd_third),
    .shared_pin_out(pin), .failsafe_reason(reason_out), .wake_max_pulse_check_off(wake_off),
    .soft_reset_out(soft_out), .por_request(por), .power_up_set(pup), .wake_ignore_lock(lock));

  fsrpc_host_model host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Pulse: 0 fallback set, 1 first good trigger, 2 third, 3 fail-safe entry
  task automatic pulse(input int k);
    @(posedge clk);
    fb_set   <= (k == 0);
    wd_first <= (k == 1);
    wd_third <= (k == 2);
    fs_entry <= (k == 3);
    @(posedge clk);
    {fb_set, wd_first, wd_third, fs_entry} <= 4'h0;
  endtask

  // Free running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(40 * 8000);
    err_total++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    // Address, write data, expected read back
    rows = '{24'h185A50, 24'h19FC00, 24'h1AFE7C, 24'h1A0000, 24'h1BFF02, 24'h20FF00};
    {sys_rst, sleep_mode, fs_entry, cnt_en, fb_set, wd_first, wd_third} = 7'h40;
    {io_supply, reason, act} = 7'h40;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(pin, 1);
    for (int i = 0; i < 4; i++) begin
      host.rd(8'h18 + i[7:0], d);
      chk(d, 0);
    end
    foreach (rows[i]) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], d);
      chk(d, rows[i][7:0]);
    end
    chk(wake_off, 1);
    // Access in sleep only with the IO supply present
    sleep_mode <= 1'b1;
    io_supply  <= 1'b0;
    host.wr(8'h1B, 8'h00);
    io_supply <= 1'b1;
    host.rd(8'h1B, d);
    chk(d, 8'h02);
    host.wr(8'h1B, 8'h00);
    host.rd(8'h1B, d);
    chk(d, 8'h00);
    chk(wake_off, 0);
    sleep_mode <= 1'b0;
    // Counting saturates, reason held, clear by zero, enable gates counting
    cnt_en <= 1'b1;
    reason <= 3'h3;
    host.wr(8'h18, 8'hF0);
    repeat (17) pulse(3);
    host.rd(8'h18, d);
    chk(d, 8'hFF);
    chk(reason_out, 3);
    host.wr(8'h18, 8'hF0);
    host.rd(8'h18, d);
    chk(d, 8'hF0);
    chk(reason_out, 0);
    cnt_en <= 1'b0;
    pulse(3);
    host.rd(8'h18, d);
    chk(d, 8'hF0);
    cnt_en <= 1'b1;
    // Each action with threshold 1: fires on the second entry only
    for (int a = 0; a < 5; a++) begin
      @(posedge clk);
      act <= a[2:0];
      host.wr(8'h18, 8'h10);
      pulse(3);
      #1 chk({soft_out, por}, 0);
      pulse(3);
      #1 chk({soft_out, por, pup}, {a == 2, a == 3, a == 3});
      repeat (5) @(posedge clk);
      #1 chk(pin, a != 1);
      repeat (25) @(posedge clk);
      #1 chk({pin, lock}, {1'b1, a == 4});
    end
    // Soft reset keeps the regulator on, hard reset raises power-up
    host.wr(8'h1A, 8'h08);
    host.wr(8'h19, 8'h02);
    #1 chk({soft_out, pin}, 2'b11);
    host.rd(8'h1A, d);
    chk(d, 0);
    host.rd(8'h19, d);
    chk(d, 0);
    host.wr(8'h19, 8'h01);
    #1 chk({por, pup}, 2'b11);
    host.rd(8'h19, d);
    chk(d, 0);
    // Fallback turn-off per method; a wrong trigger leaves it on
    for (int m = 0; m < 3; m++) begin
      host.wr(8'h1A, {4'h2, m[1:0], 2'b00});
      pulse(0);
      repeat (3) @(posedge clk);
      #1 chk(pin, 1);
      if (m == 2) pulse(1);
      else host.wr(8'h1A, {4'h2, m[1:0], 2'b10});
      repeat (3) @(posedge clk);
      #1 chk(pin, 1);
      if (m == 2) host.wr(8'h1A, 8'h2A);
      else pulse(2 - m);
      repeat (3) @(posedge clk);
      #1 chk(pin, 0);
      host.rd(8'h1A, d);
      chk(d, {4'h2, m[1:0], 2'b00});
    end
    // Reserved method: no trigger and no write may turn the indicator off
    host.wr(8'h1A, 8'h2C);
    pulse(0);
    pulse(1);
    pulse(2);
    host.wr(8'h1A, 8'h2E);
    repeat (3) @(posedge clk);
    #1 chk(pin, 1);
    host.wr(8'h1A, 8'h30);
    pulse(0);
    repeat (3) @(posedge clk);
    #1 chk(pin, 0);
    host.wr(8'h1A, 8'h40);
    repeat (3) @(posedge clk);
    #1 chk(pin, 0);
    // Sleep lock leaves only through system reset
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk(lock, 0);
    chk(pin, 1);
    host.rd(8'h1A, d);
    chk(d, 8'h00);
    close_out();
  end
endmodule
